// File: bmc_core.sv
/*
  Register-controlled core of a bus performance monitor: control word, ID filter,
  latency range bucket counters, log cut-off compare and the snapshot registers.
  Assumes the metric counters, slot measurement logic and sample interval counter
  run on pclk beside it; only the external event pins are asynchronous.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_map.svh"

module bmc_core
  import bmc_pkg::*;
#(
  parameter int NUM_CNT = 10,
  parameter int ID_W = 16,
  parameter bit EN_TRIGGER = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`BMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic advanced_mode,
  input wire logic profile_mode,
  input wire logic [NUM_CNT-1:0][31:0] metric_count,
  input wire logic [NUM_CNT-1:0][15:0] lat_max,
  input wire logic [NUM_CNT-1:0][15:0] lat_min,
  input wire logic [NUM_CNT-1:0] bucket_valid,
  input wire logic [NUM_CNT-1:0][31:0] bucket_value,
  input wire logic sample_ovf,
  input wire logic sample_reg_read,
  input wire logic gcc_ovf,
  input wire logic sw_data_written,
  input wire logic [6:0] slot_ev,
  input wire logic [ID_W-1:0] txn_rid,
  input wire logic [ID_W-1:0] txn_wid,
  input wire logic ext_trig,
  input wire logic ext_capture,
  input wire logic ext_ev_start,
  input wire logic ext_ev_stop,
  input wire logic ext_ev,
  output logic metrics_run,
  output logic metrics_reset,
  output logic gcc_run,
  output logic gcc_reset,
  output logic fifo_reset,
  output logic trig_path_reset,
  output logic log_on,
  output logic log_event,
  output bmc_lat_sel_s lat_sel,
  output logic id_filter_on,
  output logic rid_match,
  output logic wid_match
);

  logic [31:0] ctrl;
  logic [31:0] flags;
  logic [31:0] id_match_low;
  logic [31:0] id_mask_low;
  logic [31:0] id_match_high;
  logic [31:0] id_mask_high;
  logic [NUM_CNT-1:0][31:0] range_limits;
  logic [NUM_CNT-1:0][31:0] log_cutoff;
  logic [NUM_CNT-1:0][31:0] bucket_cnt;
  logic [NUM_CNT-1:0][31:0] sampled_metric_count;
  logic [NUM_CNT-1:0][31:0] sampled_bucket_count;
  logic [NUM_CNT-1:0] cut_hit;
  logic [NUM_CNT-1:0] cut_hit_q;
  logic [`BMC_FB_CUT_N-1:0] cut_cross;
  logic [2:0] rst_cnt;
  logic wr_en;
  logic [31:0] next_rdata;
  logic next_hit;
  bmc_ext_s ext_meta;
  bmc_ext_s ext_sync;
  bmc_ext_s ext_prev;
  bmc_ext_s ext_rise;
  logic capture;
  logic trig_seen;
  logic log_seen;
  logic log_wait;
  logic [31:0] log_src;

  function automatic logic [`BMC_ADDR_W-1:0] reg_addr(
    input logic [`BMC_ADDR_W-1:0] base,
    input logic [`BMC_ADDR_W-1:0] stride,
    input int idx
  );
    return base + `BMC_ADDR_W'(idx) * stride;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb,
    input logic [31:0] keep
  );
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old_val & ~m) | (new_val & m)) & keep;
  endfunction

  // Write completes at the access edge where pready is seen high
  assign wr_en = psel && penable && pwrite && pready;

  // Bus answer: data is fetched in the setup cycle so the access phase has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= `BMC_RESET_VAL;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      prdata <= pwrite ? `BMC_RESET_VAL : next_rdata;
      pslverr <= !next_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = `BMC_RESET_VAL;
    next_hit = 1'b1;
    unique case (paddr)
      `BMC_CTRL_ADDR: next_rdata = ctrl;
      `BMC_FLAG_ADDR: next_rdata = flags;
      `BMC_IDM_LO_ADDR: next_rdata = id_match_low;
      `BMC_IDK_LO_ADDR: next_rdata = id_mask_low;
      `BMC_IDM_HI_ADDR: next_rdata = id_match_high;
      `BMC_IDK_HI_ADDR: next_rdata = id_mask_high;
      default: next_hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_CNT; i++) begin
      if (paddr == reg_addr(`BMC_RANGE_BASE, `BMC_STRIDE, i)) begin
        next_rdata = range_limits[i];
        next_hit = 1'b1;
      end
      if (paddr == reg_addr(`BMC_CUTOFF_BASE, `BMC_STRIDE, i)) begin
        next_rdata = log_cutoff[i];
        next_hit = 1'b1;
      end
      // Profile counters would collide with the control window, so they read elsewhere
      if (i < `BMC_PROFILE_FIRST) begin
        if (paddr == reg_addr(`BMC_SNAP_M_BASE, `BMC_STRIDE, i)) begin
          next_rdata = sampled_metric_count[i];
          next_hit = 1'b1;
        end
        if (paddr == reg_addr(`BMC_SNAP_B_BASE, `BMC_STRIDE, i)) begin
          next_rdata = sampled_bucket_count[i];
          next_hit = 1'b1;
        end
      end else if (paddr == reg_addr(`BMC_PROF_BASE, `BMC_PROF_STRIDE,
                                     i - `BMC_PROFILE_FIRST)) begin
        next_rdata = sampled_metric_count[i];
        next_hit = 1'b1;
      end
    end
  end

  // Control word and flag enables; reserved bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `BMC_RESET_VAL;
      flags <= `BMC_RESET_VAL;
    end else if (wr_en) begin
      if (paddr == `BMC_CTRL_ADDR) begin
        ctrl <= merge(ctrl, pwdata, pstrb, `BMC_CTRL_MASK);
      end
      if (paddr == `BMC_FLAG_ADDR) begin
        flags <= merge(flags, pwdata, pstrb, `BMC_FLAG_MASK);
      end
    end
  end

  // Read ID in the top half, write ID in the bottom half of each register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_match_low <= `BMC_RESET_VAL;
      id_mask_low <= `BMC_RESET_VAL;
      id_match_high <= `BMC_RESET_VAL;
      id_mask_high <= `BMC_RESET_VAL;
    end else if (wr_en) begin
      unique case (paddr)
        `BMC_IDM_LO_ADDR: id_match_low <= merge(id_match_low, pwdata, pstrb, '1);
        `BMC_IDK_LO_ADDR: id_mask_low <= merge(id_mask_low, pwdata, pstrb, '1);
        `BMC_IDM_HI_ADDR: id_match_high <= merge(id_match_high, pwdata, pstrb, '1);
        `BMC_IDK_HI_ADDR: id_mask_high <= merge(id_mask_high, pwdata, pstrb, '1);
        default: ;
      endcase
    end
  end

  // Only the second synchroniser stage feeds the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= '0;
      ext_sync <= '0;
      ext_prev <= '0;
    end else begin
      ext_meta <= '{trig: ext_trig, capture: ext_capture, ev_start: ext_ev_start,
                    ev_stop: ext_ev_stop, ev: ext_ev};
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync & ~ext_prev;
  assign capture = ext_rise.capture || sample_ovf || sample_reg_read;

  // Counter reset stays asserted five cycles after software drops the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= '0;
      metrics_reset <= 1'b0;
    end else begin
      if (ctrl[`BMC_CB_CNT_RST]) begin
        rst_cnt <= `BMC_RST_RELEASE_CYC;
      end else if (rst_cnt != '0) begin
        rst_cnt <= rst_cnt - 3'h1;
      end
      metrics_reset <= ctrl[`BMC_CB_CNT_RST] || (rst_cnt != '0);
    end
  end

  // Trigger latches; the FIFO reset bit clears them when the trigger path exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_seen <= 1'b0;
      log_seen <= 1'b0;
    end else if (EN_TRIGGER && ctrl[`BMC_CB_FIFO_RST]) begin
      trig_seen <= 1'b0;
      log_seen <= 1'b0;
    end else begin
      if (!ctrl[`BMC_CB_CNT_EN]) begin
        trig_seen <= 1'b0;
      end else if (ext_rise.trig) begin
        trig_seen <= 1'b1;
      end
      if (!ctrl[`BMC_CB_LOG_EN]) begin
        log_seen <= 1'b0;
      end else if ((ctrl[`BMC_CB_LOG_TRIG] && ext_rise.trig) || (|cut_cross)) begin
        log_seen <= 1'b1;
      end
    end
  end

  // Logging waits for a start only when a trigger or a cut-off flag is armed
  assign log_wait = ctrl[`BMC_CB_LOG_TRIG] || (|flags[`BMC_FB_CUT0 +: `BMC_FB_CUT_N]);
  assign log_src = {cut_cross, ext_rise.ev_start ? 1'b0 : 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                    1'b0, 16'h0000} | {10'h000, sample_ovf, gcc_ovf, ext_rise.ev_start,
                    ext_rise.ev_stop, ext_rise.ev, sw_data_written, 9'h000, slot_ev};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      metrics_run <= 1'b0;
      log_on <= 1'b0;
      log_event <= 1'b0;
    end else begin
      metrics_run <= ctrl[`BMC_CB_CNT_EN] && !metrics_reset
                     && (!ctrl[`BMC_CB_USE_TRIG] || trig_seen);
      log_on <= ctrl[`BMC_CB_LOG_EN] && (!log_wait || log_seen);
      log_event <= log_on && (|(log_src & flags));
    end
  end

  // Control outputs, mode-gated for the global counter and ID filter, and latency point selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcc_run <= 1'b0;
      gcc_reset <= 1'b0;
      fifo_reset <= 1'b0;
      trig_path_reset <= 1'b0;
      lat_sel <= '0;
      id_filter_on <= 1'b0;
    end else begin
      gcc_run <= advanced_mode && ctrl[`BMC_CB_GCC_EN];
      gcc_reset <= advanced_mode && ctrl[`BMC_CB_GCC_RST];
      fifo_reset <= ctrl[`BMC_CB_FIFO_RST];
      trig_path_reset <= EN_TRIGGER && ctrl[`BMC_CB_FIFO_RST];
      lat_sel.rd_end_first <= ctrl[`BMC_CB_RD_END];
      lat_sel.rd_start_hs <= ctrl[`BMC_CB_RD_START];
      lat_sel.wr_end_first <= ctrl[`BMC_CB_WR_END];
      lat_sel.wr_start_hs <= ctrl[`BMC_CB_WR_START];
      id_filter_on <= advanced_mode && ctrl[`BMC_CB_ID_FILT];
    end
  end

  // ID compare: masked bits are don't-care; upper registers cover IDs past 16 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rid_match <= 1'b1;
      wid_match <= 1'b1;
    end else begin
      logic [31:0] rid_ref;
      logic [31:0] rid_msk;
      logic [31:0] wid_ref;
      logic [31:0] wid_msk;
      rid_ref = {id_match_high[31:16], id_match_low[31:16]};
      rid_msk = {id_mask_high[31:16], id_mask_low[31:16]};
      wid_ref = {id_match_high[15:0], id_match_low[15:0]};
      wid_msk = {id_mask_high[15:0], id_mask_low[15:0]};
      rid_match <= !id_filter_on
                   || (((txn_rid ^ rid_ref[ID_W-1:0]) & ~rid_msk[ID_W-1:0]) == '0);
      wid_match <= !id_filter_on
                   || (((txn_wid ^ wid_ref[ID_W-1:0]) & ~wid_msk[ID_W-1:0]) == '0);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          range_limits[g] <= `BMC_RESET_VAL;
          log_cutoff[g] <= `BMC_RESET_VAL;
        end else if (wr_en) begin
          if (paddr == reg_addr(`BMC_RANGE_BASE, `BMC_STRIDE, g)) begin
            range_limits[g] <= merge(range_limits[g], pwdata, pstrb, '1);
          end
          if (paddr == reg_addr(`BMC_CUTOFF_BASE, `BMC_STRIDE, g)) begin
            log_cutoff[g] <= merge(log_cutoff[g], pwdata, pstrb, '1);
          end
        end
      end

      // Inclusive range: low limit in the bottom half, high limit in the top half
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bucket_cnt[g] <= `BMC_RESET_VAL;
        end else if (metrics_reset) begin
          bucket_cnt[g] <= `BMC_RESET_VAL;
        end else if (metrics_run && bucket_valid[g]
                     && bucket_value[g] >= {16'h0000, range_limits[g][`BMC_HALF-1:0]}
                     && bucket_value[g] <= {16'h0000, range_limits[g][31:`BMC_HALF]}) begin
          bucket_cnt[g] <= bucket_cnt[g] + 32'h0000_0001;
        end
      end

      // Metric values arrive on pclk already, so the snapshot loads with no extra stage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sampled_metric_count[g] <= `BMC_RESET_VAL;
          sampled_bucket_count[g] <= `BMC_RESET_VAL;
        end else if (metrics_reset) begin
          sampled_metric_count[g] <= `BMC_RESET_VAL;
          sampled_bucket_count[g] <= `BMC_RESET_VAL;
        end else if (capture) begin
          if (profile_mode && g >= `BMC_PROFILE_FIRST) begin
            sampled_metric_count[g] <= {lat_max[g], lat_min[g]};
          end else begin
            sampled_metric_count[g] <= metric_count[g];
          end
          sampled_bucket_count[g] <= bucket_cnt[g];
        end
      end

      assign cut_hit[g] = metric_count[g] >= log_cutoff[g];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cut_hit_q[g] <= 1'b0;
        end else begin
          cut_hit_q[g] <= cut_hit[g];
        end
      end
    end

    // A crossing is the cycle the compare first turns true
    for (g = 0; g < `BMC_FB_CUT_N; g++) begin : g_cross
      if (g < NUM_CNT) begin : g_on
        assign cut_cross[g] = cut_hit[g] && !cut_hit_q[g]
                              && flags[`BMC_FB_CUT0 + g];
      end else begin : g_off
        assign cut_cross[g] = 1'b0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: bmc_map.svh
/*
  Address map, field positions, reset values and timing counts of the bus monitor
  control block. Assumes an APB slave with 12-bit byte addresses and 32-bit data.
*/
// Summary of operation
// - Range register: upper limit high, lower low
// - Metric count at or above cut-off enables logging
// - Capture event copies metric counters into snapshots
// - Capture event copies bucket counters into snapshots
// - Profile counters 48-63 snapshot max/min latency
// - Bit 25 resets log FIFO and trigger path
// - Bits 17/16 reset and enable global counter in advanced mode
// - Bit 8 enables logging, bit 9 trigger start
// - Bit 7 selects first or last read beat
// - Bit 6 selects read start: valid or handshake
// - Bit 5 selects first or last write beat
// - Bit 4 selects write start: valid or handshake
// - Bit 3 restricts metrics to matching IDs in advanced mode
// - Bit 2 lets external trigger start counters
// - Bit 1 resets counters, release five cycles later
// - Bit 0 enables all metric counters
// - Set mask bits exclude ID bits from match
// - Flag bits 31-22 log on counter cut-off crossing
// - Flag bits 21/20/19: lapse, overflow, event start
// - Snapshots live in the register bus domain
// - Bucket counters count in-range values, reset zero
// - Flag bits 18/17/16: stop, event, software write
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH

`define BMC_ADDR_W 12
`define BMC_RANGE_BASE 12'h108
`define BMC_CUTOFF_BASE 12'h10C
`define BMC_SNAP_M_BASE 12'h200
`define BMC_SNAP_B_BASE 12'h204
`define BMC_STRIDE 12'h010
`define BMC_PROF_BASE 12'h500
`define BMC_PROF_STRIDE 12'h004
`define BMC_CTRL_ADDR 12'h300
`define BMC_IDM_LO_ADDR 12'h304
`define BMC_IDK_LO_ADDR 12'h308
`define BMC_IDM_HI_ADDR 12'h30C
`define BMC_IDK_HI_ADDR 12'h310
`define BMC_FLAG_ADDR 12'h400

`define BMC_RESET_VAL 32'h0000_0000
`define BMC_CTRL_MASK 32'h0203_03FF
`define BMC_FLAG_MASK 32'hFFFF_007F

`define BMC_CB_CNT_EN 0
`define BMC_CB_CNT_RST 1
`define BMC_CB_USE_TRIG 2
`define BMC_CB_ID_FILT 3
`define BMC_CB_WR_START 4
`define BMC_CB_WR_END 5
`define BMC_CB_RD_START 6
`define BMC_CB_RD_END 7
`define BMC_CB_LOG_EN 8
`define BMC_CB_LOG_TRIG 9
`define BMC_CB_GCC_EN 16
`define BMC_CB_GCC_RST 17
`define BMC_CB_FIFO_RST 25

`define BMC_FB_CUT0 22
`define BMC_FB_CUT_N 10
`define BMC_PROFILE_FIRST 48
`define BMC_HALF 16

`define BMC_RST_RELEASE_CYC 3'h5

`endif

// File: bmc_pkg.sv
/*
  Types shared by the bus monitor control block.
  Assumes the constants of bmc_map.svh are included wherever numbers are needed.
*/
`default_nettype none
package bmc_pkg;

  // Latency start and end point selects sent to the slot measurement logic
  typedef struct packed {
    logic rd_end_first;
    logic rd_start_hs;
    logic wr_end_first;
    logic wr_start_hs;
  } bmc_lat_sel_s;

  // External pins, in the order they travel through the synchroniser
  typedef struct packed {
    logic trig;
    logic capture;
    logic ev_start;
    logic ev_stop;
    logic ev;
  } bmc_ext_s;

endpackage
`default_nettype wire

// File: bmc_checker.sv
/* Concurrent checks on the bmc_core ports.
   Assumes one clock, pclk, and presetn as asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "bmc_map.svh"
module bmc_checker
  import bmc_pkg::*;
#(
  parameter bit EN_TRIGGER = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`BMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic advanced_mode,
  input wire logic metrics_run,
  input wire logic metrics_reset,
  input wire logic gcc_run,
  input wire logic fifo_reset,
  input wire logic trig_path_reset,
  input wire bmc_lat_sel_s lat_sel,
  input wire logic id_filter_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence ctrl_wr_s;
    psel && penable && pready && pwrite && paddr == `BMC_CTRL_ADDR;
  endsequence
  answer_next_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_reads_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  lat_follow_a: assert property (
    ctrl_wr_s |-> ##2 lat_sel == $past(pwdata[7:4], 2))
    else $error("latency selects do not follow control word");
  fifo_pair_a: assert property ($rose(fifo_reset) |-> trig_path_reset == EN_TRIGGER)
    else $error("trigger path reset disagrees with fifo reset");
  gcc_mode_a: assert property (gcc_run |-> $past(advanced_mode))
    else $error("global counter runs outside advanced mode");
  filt_mode_a: assert property (id_filter_on |-> $past(advanced_mode))
    else $error("id filter on outside advanced mode");
  run_gate_a: assert property ($rose(metrics_reset) |=> !metrics_run)
    else $error("counters run during metric reset");
  reset_release_a: assert property (
    ctrl_wr_s ##0 (!pwdata[1] && metrics_reset) |=> metrics_reset[*5] ##[1:2] !metrics_reset)
    else $error("metric reset release not five cycles");
endmodule
bind bmc_core bmc_checker #(.EN_TRIGGER(EN_TRIGGER)) u_bmc_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .advanced_mode(advanced_mode), .metrics_run(metrics_run), .metrics_reset(metrics_reset),
  .gcc_run(gcc_run), .fifo_reset(fifo_reset), .trig_path_reset(trig_path_reset),
  .lat_sel(lat_sel), .id_filter_on(id_filter_on));
`default_nettype wire

// File: bmc_slot_model.sv
/* Behavioural model of the monitor slots feeding the control block.
   Assumes the bench steers it through its tasks and its count variables. */
`timescale 1ns/1ps
`default_nettype none
module bmc_slot_model #(
  parameter int NUM_CNT = 10
) (
  input wire logic pclk,
  output logic [NUM_CNT-1:0][31:0] metric_count,
  output logic [NUM_CNT-1:0] bucket_valid,
  output logic [NUM_CNT-1:0][31:0] bucket_value,
  output logic sample_reg_read
);
  initial begin
    metric_count = '0;
    bucket_valid = '0;
    bucket_value = '0;
    sample_reg_read = 1'b0;
  end
  // One finished latency measurement; the value is scrambled after so a stale hold shows
  task automatic measure(input int i, input logic [31:0] v);
    @(posedge pclk);
    bucket_valid[i] <= 1'b1;
    bucket_value[i] <= v;
    @(posedge pclk);
    bucket_valid[i] <= 1'b0;
    bucket_value[i] <= ~v;
  endtask
  task automatic capture();
    @(posedge pclk);
    sample_reg_read <= 1'b1;
    @(posedge pclk);
    sample_reg_read <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bus_monitor_control_regs_test.sv
/* Self-checking bench for bmc_core with an APB master and the slot model.
   Assumes bmc_checker is bound to the core and pclk runs at 40 MHz. */
`timescale 1ns/1ps
`default_nettype none
`include "bmc_map.svh"
module bus_monitor_control_regs_test;
  import bmc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, adv = 1'b0;
  logic [9:0][31:0] mc, bv;
  logic [9:0] bval;
  logic srr, m_run, m_rst, g_run, g_rst, f_rst, t_rst, l_on, l_ev, filt, r_m, w_m;
  logic [15:0] read_id_field = '0, write_id_field = '0;
  logic [6:0] slot_ev = '0;
  bmc_lat_sel_s lsel;
  int fails = 0;
  int n_tests = 0;
  always #12.5 pclk = ~pclk;
  bmc_slot_model u_bmc_slot_model (.pclk(pclk), .metric_count(mc), .bucket_valid(bval),
    .bucket_value(bv), .sample_reg_read(srr));
  bmc_core u_bmc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .advanced_mode(adv), .profile_mode(1'b0),
    .metric_count(mc), .lat_max('0), .lat_min('0), .bucket_valid(bval),
    .bucket_value(bv), .sample_ovf(1'b0), .sample_reg_read(srr), .gcc_ovf(slot_ev[0]),
    .sw_data_written(slot_ev[1]), .slot_ev(slot_ev), .txn_rid(read_id_field), .txn_wid(write_id_field),
    .ext_trig(slot_ev[2]), .ext_capture(slot_ev[3]), .ext_ev_start(slot_ev[4]),
    .ext_ev_stop(slot_ev[5]), .ext_ev(slot_ev[6]), .metrics_run(m_run),
    .metrics_reset(m_rst), .gcc_run(g_run), .gcc_reset(g_rst), .fifo_reset(f_rst),
    .trig_path_reset(t_rst), .log_on(l_on), .log_event(l_ev), .lat_sel(lsel),
    .id_filter_on(filt), .rid_match(r_m), .wid_match(w_m));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is seen at a rising edge; no wait count assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      fails++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  task automatic t_reset_vals();
    logic [11:0] adr [8] = '{`BMC_RANGE_BASE, `BMC_CUTOFF_BASE, `BMC_SNAP_M_BASE,
      `BMC_SNAP_B_BASE, `BMC_CTRL_ADDR, `BMC_IDM_LO_ADDR, `BMC_IDK_HI_ADDR, `BMC_FLAG_ADDR};
    foreach (adr[i]) rdc("reset value", adr[i], `BMC_RESET_VAL);
    chk("id match idle", {r_m, w_m}, 32'h0000_0003);
    $display("t_reset_vals done");
  endtask
  task automatic t_masks();
    wr(`BMC_CTRL_ADDR, 32'hFFFF_FFFF);
    rdc("control", `BMC_CTRL_ADDR, `BMC_CTRL_MASK);
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    tick(8);
    wr(`BMC_FLAG_ADDR, 32'hFFFF_FFFF);
    rdc("flags", `BMC_FLAG_ADDR, `BMC_FLAG_MASK);
    wr(`BMC_FLAG_ADDR, 32'h0000_0000);
    wr(`BMC_RANGE_BASE, 32'h1234_5678);
    rdc("range", `BMC_RANGE_BASE, 32'h1234_5678);
    wr(`BMC_SNAP_M_BASE, 32'hFFFF_FFFF);
    rdc("snapshot ro", `BMC_SNAP_M_BASE, 32'h0000_0000);
    apb(1'b0, 12'h0F0, 32'h0000_0000);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    $display("t_masks done");
  endtask
  task automatic t_ctrl_outs();
    adv <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr(`BMC_CTRL_ADDR, 32'(i) << 4);
      tick(2);
      chk("lat_sel", 32'(lsel), 32'(i));
    end
    wr(`BMC_CTRL_ADDR, 32'h0203_0008);
    tick(2);
    chk("ctrl outs", {g_run, g_rst, f_rst, t_rst, filt}, 32'h0000_001F);
    adv <= 1'b0;
    tick(3);
    chk("basic mode", {g_run, g_rst, filt}, 32'h0000_0000);
    adv <= 1'b1;
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    $display("t_ctrl_outs done");
  endtask
  task automatic t_id();
    wr(`BMC_CTRL_ADDR, 32'h0000_0008);
    wr(`BMC_IDM_LO_ADDR, 32'h0005_0003);
    read_id_field <= 16'h0005;
    write_id_field <= 16'h0003;
    tick(3);
    chk("id hit", {r_m, w_m}, 32'h0000_0003);
    read_id_field <= 16'h0004;
    tick(3);
    chk("id miss", {r_m, w_m}, 32'h0000_0001);
    wr(`BMC_IDK_LO_ADDR, 32'h0001_0000);
    tick(3);
    chk("id masked", {r_m, w_m}, 32'h0000_0003);
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    $display("t_id done");
  endtask
  task automatic t_bucket();
    logic [31:0] vals [5] = '{32'h0000_0003, 32'h0000_0004, 32'h0000_000A,
      32'h0000_000B, 32'h0001_0007};
    wr(`BMC_RANGE_BASE, 32'h000A_0004);
    wr(`BMC_CTRL_ADDR, 32'h0000_0001);
    tick(3);
    foreach (vals[i]) u_bmc_slot_model.measure(0, vals[i]);
    u_bmc_slot_model.measure(1, 32'h0000_0005);
    u_bmc_slot_model.metric_count[0] <= 32'h0000_1234;
    u_bmc_slot_model.capture();
    tick(2);
    rdc("bucket0", `BMC_SNAP_B_BASE, 32'h0000_0002);
    rdc("bucket1", `BMC_SNAP_B_BASE + `BMC_STRIDE, 32'h0000_0000);
    rdc("metric0", `BMC_SNAP_M_BASE, 32'h0000_1234);
    wr(`BMC_CTRL_ADDR, 32'h0000_0002);
    tick(3);
    chk("reset held", 32'(m_rst), 32'h0000_0001);
    rdc("metric0 cleared", `BMC_SNAP_M_BASE, 32'h0000_0000);
    rdc("bucket0 cleared", `BMC_SNAP_B_BASE, 32'h0000_0000);
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    // Counter reset still shows on the sixth edge after the clearing write
    tick(6);
    chk("reset release", 32'(m_rst), 32'h0000_0001);
    tick(1);
    chk("reset released", 32'(m_rst), 32'h0000_0000);
    $display("t_bucket done");
  endtask
  task automatic t_log();
    wr(`BMC_CUTOFF_BASE, 32'h0000_1000);
    wr(`BMC_FLAG_ADDR, 32'h0040_0000);
    u_bmc_slot_model.metric_count[0] <= 32'h0000_0FFF;
    wr(`BMC_CTRL_ADDR, 32'h0000_0101);
    tick(4);
    chk("log below cut-off", 32'(l_on), 32'h0000_0000);
    u_bmc_slot_model.metric_count[0] <= 32'h0000_1000;
    tick(4);
    chk("log at cut-off", 32'(l_on), 32'h0000_0001);
    wr(`BMC_FLAG_ADDR, 32'h0000_0000);
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    tick(3);
    chk("log off", 32'(l_on), 32'h0000_0000);
    wr(`BMC_CTRL_ADDR, 32'h0000_0100);
    tick(3);
    chk("log by control", 32'(l_on), 32'h0000_0001);
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    $display("t_log done");
  endtask
  // Pins pass two sync stages and an edge detect before the registered outputs
  task automatic t_events();
    wr(`BMC_FLAG_ADDR, 32'h0002_0000);
    wr(`BMC_CTRL_ADDR, 32'h0000_0105);
    tick(3);
    chk("run waits trigger", 32'(m_run), 32'h0000_0000);
    slot_ev <= 7'h44;
    tick(4);
    chk("event logged", 32'(l_ev), 32'h0000_0001);
    tick(1);
    chk("event pulse", 32'(l_ev), 32'h0000_0000);
    chk("run on trigger", 32'(m_run), 32'h0000_0001);
    slot_ev <= 7'h00;
    wr(`BMC_CTRL_ADDR, 32'h0000_0000);
    wr(`BMC_FLAG_ADDR, 32'h0000_0000);
    $display("t_events done");
  endtask
  initial begin
    tick(10);
    presetn <= 1'b1;
    t_reset_vals();
    t_masks();
    t_ctrl_outs();
    t_id();
    t_bucket();
    t_log();
    t_events();
    close_out();
  end
  // Guards against a hung handshake anywhere in the run
  initial begin
    tick(20000);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
